// *** rtl/msw_ctrl_regs.sv ***
// Purpose: Mode, supply and watchdog control register bank with derived controls.
// Assumes: Command fields arrive already decoded as one-cycle strobe.
// Notes: Read data is the register value before any write of the same command.
module msw_ctrl_regs (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic cmd_valid_in,
  input wire logic [6:0] cmd_addr_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic restart_in,
  input wire logic overtemp_in,
  input wire logic overvoltage_in,
  input wire logic supply_undervoltage_in,
  input wire logic fault_failure_in,
  input wire logic failure_flag_clear_in,
  input wire logic bus_wake_in,
  input wire logic wd_fail_in,
  input wire logic fail_safe_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [1:0] mode_out,
  output logic soft_reset_out,
  output logic reset_output_low_out,
  output logic second_regulator_on_out,
  output logic third_regulator_on_out,
  output logic third_regulator_alt_voltage_out,
  output logic load_sharing_out,
  output logic [1:0] reset_threshold_out,
  output logic main_overvoltage_flag_out,
  output logic overvoltage_restart_out,
  output logic failure_outputs_out,
  output logic watchdog_active_out,
  output logic watchdog_window_out,
  output logic watchdog_long_open_out,
  output logic watchdog_escalate_out,
  output logic [2:0] watchdog_period_out
);
  import msw_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] mode_and_supply_control;
  logic [7:0] hardware_supply_config;
  logic [7:0] watchdog_control;
  logic fault_latched;
  logic wd_fail_seen;
  logic wr_mode, wr_hw, wr_wd, soft_req;
  logic [1:0] cur_mode;

  // Write decode; access bit set means write
  assign wr_mode = cmd_valid_in && cmd_write_in && cmd_addr_in == MSW_ADDR_MODE;
  assign wr_hw = cmd_valid_in && cmd_write_in && cmd_addr_in == MSW_ADDR_HW;
  assign wr_wd = cmd_valid_in && cmd_write_in && cmd_addr_in == MSW_ADDR_WD;
  assign cur_mode = mode_and_supply_control[MSW_MODE_HI:MSW_MODE_LO];
  assign soft_req = wr_mode && cmd_data_in[7:6] == MSW_CODE_SOFT;

  // ----------------------------------------------------------------
  // Mode and supply control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in || soft_reset_out) begin
      mode_and_supply_control <= MSW_RST_MODE;
    end else begin
      if (wr_mode) begin
        mode_and_supply_control <= cmd_data_in;
        // Stop to sleep by write is refused, mode stays stop
        if (cur_mode == MSW_CODE_STOP && cmd_data_in[7:6] == MSW_CODE_SLEEP) begin
          mode_and_supply_control[MSW_MODE_HI:MSW_MODE_LO] <= MSW_CODE_STOP;
        end
      end
      if (restart_in) begin
        mode_and_supply_control[MSW_MODE_HI:MSW_MODE_LO] <= MSW_CODE_NORMAL;
      end
      if (restart_in || overtemp_in) begin
        mode_and_supply_control[MSW_V2_HI:MSW_V2_LO] <= MSW_V2_OFF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware supply config register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      hardware_supply_config <= MSW_RST_HW;
    end else if (soft_reset_out) begin
      hardware_supply_config <= hardware_supply_config & MSW_HW_KEEP;
    end else begin
      if (wr_hw) begin
        hardware_supply_config <= cmd_data_in & MSW_HW_MASK;
      end
      if (restart_in) begin
        hardware_supply_config[MSW_FAILURE_OUTPUT_ACTIVATION] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in || soft_reset_out) begin
      watchdog_control <= MSW_RST_WD;
    end else if (wr_wd) begin
      watchdog_control <= cmd_data_in & MSW_WD_MASK; // Reserved bit 3 reads 0
    end
  end

  // Read answer shows contents before this command's write
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= cmd_valid_in;
      if (cmd_valid_in) begin
        unique case (cmd_addr_in)
          MSW_ADDR_MODE: rd_data_out <= mode_and_supply_control;
          MSW_ADDR_HW: rd_data_out <= hardware_supply_config;
          MSW_ADDR_WD: rd_data_out <= watchdog_control;
          default: rd_data_out <= 8'h00;
        endcase
      end
    end
  end

  // Soft reset pulse and reset output low unless masked
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      soft_reset_out <= 1'b0;
      reset_output_low_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_req;
      reset_output_low_out <= soft_req && !hardware_supply_config[MSW_SR_RO];
    end
  end

  // Fault-driven failure output held until failure flag cleared
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fault_latched <= 1'b0;
    end else if (fault_failure_in) begin
      fault_latched <= 1'b1;
    end else if (failure_flag_clear_in) begin
      fault_latched <= 1'b0;
    end
  end

  // Overvoltage flag is set always, reaction gated by config
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      main_overvoltage_flag_out <= 1'b0;
      overvoltage_restart_out <= 1'b0;
    end else begin
      if (overvoltage_in) begin
        main_overvoltage_flag_out <= 1'b1;
      end
      overvoltage_restart_out <= overvoltage_in && mode_and_supply_control[MSW_OV_RX];
    end
  end

  // Watchdog failure counting for escalation choice
  always_ff @(posedge core_clk_in) begin
    if (reset_in || restart_in) begin
      wd_fail_seen <= 1'b0;
      watchdog_escalate_out <= 1'b0;
    end else begin
      watchdog_escalate_out <= wd_fail_in
        && (hardware_supply_config[MSW_CFG] || wd_fail_seen);
      if (wd_fail_in) begin
        wd_fail_seen <= 1'b1;
      end
    end
  end

  // Supply and watchdog controls decoded from the registers
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_out <= MSW_CODE_NORMAL;
      second_regulator_on_out <= 1'b0;
      third_regulator_on_out <= 1'b0;
      third_regulator_alt_voltage_out <= 1'b0;
      load_sharing_out <= 1'b0;
      reset_threshold_out <= 2'h0;
      failure_outputs_out <= 1'b0;
      watchdog_active_out <= 1'b0;
      watchdog_window_out <= 1'b0;
      watchdog_long_open_out <= 1'b0;
      watchdog_period_out <= 3'h0;
    end else begin
      mode_out <= cur_mode;
      unique case (mode_and_supply_control[MSW_V2_HI:MSW_V2_LO])
        MSW_V2_OFF: second_regulator_on_out <= 1'b0;
        MSW_V2_NORM: second_regulator_on_out <= cur_mode == MSW_CODE_NORMAL;
        MSW_V2_NSTP: second_regulator_on_out <= cur_mode == MSW_CODE_NORMAL
          || cur_mode == MSW_CODE_STOP;
        default: second_regulator_on_out <= !fail_safe_in;
      endcase
      third_regulator_on_out <= mode_and_supply_control[MSW_V3_ON]
        && !(supply_undervoltage_in && !hardware_supply_config[MSW_UV_OFF])
        && !(hardware_supply_config[MSW_LS] && cur_mode == MSW_CODE_STOP
          && !hardware_supply_config[MSW_LS_STP]);
      load_sharing_out <= hardware_supply_config[MSW_LS]
        && (cur_mode != MSW_CODE_STOP || hardware_supply_config[MSW_LS_STP]);
      third_regulator_alt_voltage_out <= hardware_supply_config[MSW_V3_VCFG];
      reset_threshold_out <= mode_and_supply_control[1:0];
      failure_outputs_out <= hardware_supply_config[MSW_FAILURE_OUTPUT_ACTIVATION] || fault_latched;
      watchdog_active_out <= !(cur_mode == MSW_CODE_STOP
        && watchdog_control[MSW_WD_STM]);
      watchdog_window_out <= watchdog_control[MSW_WATCHDOG_TYPE];
      watchdog_long_open_out <= bus_wake_in && cur_mode == MSW_CODE_STOP
        && watchdog_control[MSW_WD_BUS];
      watchdog_period_out <= watchdog_control[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stop_no_sleep: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (wr_mode && cur_mode == MSW_CODE_STOP && cmd_data_in[7:6] == MSW_CODE_SLEEP
      && !restart_in) |=> mode_and_supply_control[7:6] == MSW_CODE_STOP)
    else $error("stop to sleep accepted");
  a_restart_normal: assert property (@(posedge core_clk_in) disable iff (reset_in)
    restart_in && !soft_reset_out |=> mode_and_supply_control[7:6] == MSW_CODE_NORMAL)
    else $error("restart did not set normal mode");
  a_second_reg_off: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (restart_in || overtemp_in) |=> mode_and_supply_control[4:3] == MSW_V2_OFF)
    else $error("second regulator field not cleared");
  a_read_old_value: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_hw |=> rd_valid_out && rd_data_out == $past(hardware_supply_config))
    else $error("write answer not previous value");
  a_ov_flag_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
    overvoltage_in |=> main_overvoltage_flag_out
      && overvoltage_restart_out == $past(mode_and_supply_control[2]))
    else $error("overvoltage flag or reaction wrong");
  a_soft_keep_bits: assert property (@(posedge core_clk_in) disable iff (reset_in)
    soft_reset_out |=> hardware_supply_config == ($past(hardware_supply_config) & MSW_HW_KEEP))
    else $error("soft reset changed kept bits");
  a_fo_restart: assert property (@(posedge core_clk_in) disable iff (reset_in)
    restart_in |=> !hardware_supply_config[5])
    else $error("failure output bit not cleared");
  a_fault_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fault_failure_in |=> ##1 failure_outputs_out)
    else $error("fault did not hold failure outputs");
  a_soft_ro_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
    soft_req |=> reset_output_low_out == !$past(hardware_supply_config[6]))
    else $error("reset output mask wrong");
endmodule

// *** rtl/msw_pkg.sv ***
// Purpose: Constants for the mode, supply and watchdog control register bank.
// Assumes: One 100 MHz clock; serial framing is decoded before this bank.
// Notes: Registers are reached by 7-bit address plus access bit.
// Contract
// - Mode code selects normal, sleep, stop, soft reset
// - Stop to sleep by write is refused
// - Restart rewrites mode field to normal
// - Restart or overtemperature clears second regulator field
// - Write returns previous register contents
// - Bit 5 enables third regulator
// - Second regulator field selects on modes
// - Overvoltage flag always set; reaction optional
// - Two-bit field selects reset threshold
// - Bit 7 selects third regulator voltage
// - Bit 6 masks reset output on soft reset
// - Software failure output; fault kept until cleared
// - Restart clears software failure output bit
// - Undervoltage disables third regulator unless bit 4
// - Load sharing bits 3 and 1
// - Bit 0 picks first or second watchdog failure
// - Soft reset keeps voltage bit 7 and sharing bit 3 only
// - Bit 6 deactivates watchdog in stop
// - Bit 5 selects window or time-out watchdog
// - Bit 4 starts watchdog after bus wake
// - Period codes 10 to 1000 ms, 111 reserved
// - Command is 7-bit address plus access bit
package msw_pkg;
  localparam logic [6:0] MSW_ADDR_MODE = 7'h01;
  localparam logic [6:0] MSW_ADDR_HW = 7'h02;
  localparam logic [6:0] MSW_ADDR_WD = 7'h03;
  localparam logic [7:0] MSW_RST_MODE = 8'h00;
  localparam logic [7:0] MSW_RST_HW = 8'h00;
  localparam logic [7:0] MSW_RST_WD = 8'h14;
  // Bits kept by soft reset in hardware config (bit 7 and bit 3)
  localparam logic [7:0] MSW_HW_KEEP = 8'h88;
  localparam logic [7:0] MSW_HW_MASK = 8'hFB;
  localparam logic [7:0] MSW_WD_MASK = 8'hF7;
  localparam int MSW_MODE_HI = 7;
  localparam int MSW_MODE_LO = 6;
  localparam int MSW_V3_ON = 5;
  localparam int MSW_V2_HI = 4;
  localparam int MSW_V2_LO = 3;
  localparam int MSW_OV_RX = 2;
  localparam int MSW_V3_VCFG = 7;
  localparam int MSW_SR_RO = 6;
  localparam int MSW_FAILURE_OUTPUT_ACTIVATION = 5;
  localparam int MSW_UV_OFF = 4;
  localparam int MSW_LS = 3;
  localparam int MSW_LS_STP = 1;
  localparam int MSW_CFG = 0;
  localparam int MSW_WD_STM = 6;
  localparam int MSW_WATCHDOG_TYPE = 5;
  localparam int MSW_WD_BUS = 4;
  typedef enum logic [1:0] {
    MSW_NORMAL = 2'b00,
    MSW_SLEEP = 2'b01,
    MSW_STOP = 2'b11,
    MSW_SOFTRST = 2'b10
  } msw_state_e;
  localparam logic [1:0] MSW_CODE_NORMAL = 2'h0;
  localparam logic [1:0] MSW_CODE_SLEEP = 2'h1;
  localparam logic [1:0] MSW_CODE_STOP = 2'h2;
  localparam logic [1:0] MSW_CODE_SOFT = 2'h3;
  localparam logic [1:0] MSW_V2_OFF = 2'h0;
  localparam logic [1:0] MSW_V2_NORM = 2'h1;
  localparam logic [1:0] MSW_V2_NSTP = 2'h2;
  // Watchdog period in ms per code
  localparam int MSW_CLK_MHZ = 100;
  localparam int MSW_PERIOD_MS [7] = '{10, 20, 50, 100, 200, 500, 1000};
endpackage

// *** tb/msw_host.sv ***
// Purpose: Host side model that issues decoded register commands.
// Assumes: Commands launch on the falling clock edge, one byte each.
// Notes: Watchdog writes get their checksum bit filled in here.
module msw_host (
  input wire logic core_clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic cmd_valid_out,
  output logic [6:0] cmd_addr_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_data_out,
  output logic [7:0] last_rd_out,
  output logic rd_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_addr_out = 7'h00;
    cmd_write_out = 1'b0;
    cmd_data_out = 8'h00;
    last_rd_out = 8'h00;
    rd_seen_out = 1'b0;
  end
  // One command, held a full cycle; released fields show inverted junk
  task automatic send(input logic [6:0] a, input logic w, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && a == 7'h03) begin
      v[3] = 1'b0;
      v[7] = ^v[6:0];
    end
    @(negedge core_clk_in);
    cmd_addr_out = a;
    cmd_write_out = w;
    cmd_data_out = v;
    cmd_valid_out = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    cmd_addr_out = ~a;
    cmd_data_out = ~v;
    last_rd_out = rd_data_in;
    rd_seen_out = rd_valid_in;
  endtask
endmodule

// *** tb/mode_supply_watchdog_ctrl_regs_test.sv ***
// Purpose: Self-checking bench for the mode, supply and watchdog registers.
// Assumes: Decoded commands from the host model; events as one-cycle pulses.
// Notes: Random writes are kept clear of mode changes and reserved codes.
module mode_supply_watchdog_ctrl_regs_test import msw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0, reset_in = 1'b1, cmd_valid_in, cmd_write_in;
  logic [6:0] cmd_addr_in;
  logic [7:0] cmd_data_in, rd_data_out, hrd, d;
  logic restart_in = 0, overtemp_in = 0, overvoltage_in = 0, fault_failure_in = 0;
  logic failure_flag_clear_in = 0, supply_undervoltage_in = 0, bus_wake_in = 0;
  logic wd_fail_in = 0, fail_safe_in = 0, hseen, seen;
  logic rd_valid_out, soft_reset_out, reset_output_low_out, second_regulator_on_out;
  logic third_regulator_on_out, third_regulator_alt_voltage_out, load_sharing_out;
  logic main_overvoltage_flag_out, overvoltage_restart_out, failure_outputs_out;
  logic watchdog_active_out, watchdog_window_out, watchdog_long_open_out;
  logic watchdog_escalate_out;
  logic [1:0] mode_out, reset_threshold_out;
  logic [2:0] watchdog_period_out;
  logic [7:0] shadow [4];
  logic [6:0] a;
  int n_fail = 0, total_checks = 0, cyc = 0;
  // Clock and timeout
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  msw_ctrl_regs u_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
    .cmd_addr_in(cmd_addr_in), .cmd_write_in(cmd_write_in), .cmd_data_in(cmd_data_in),
    .restart_in(restart_in), .overtemp_in(overtemp_in), .overvoltage_in(overvoltage_in),
    .supply_undervoltage_in(supply_undervoltage_in), .fault_failure_in(fault_failure_in),
    .failure_flag_clear_in(failure_flag_clear_in), .bus_wake_in(bus_wake_in),
    .wd_fail_in(wd_fail_in), .fail_safe_in(fail_safe_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .mode_out(mode_out), .soft_reset_out(soft_reset_out),
    .reset_output_low_out(reset_output_low_out),
    .second_regulator_on_out(second_regulator_on_out),
    .third_regulator_on_out(third_regulator_on_out),
    .third_regulator_alt_voltage_out(third_regulator_alt_voltage_out),
    .load_sharing_out(load_sharing_out), .reset_threshold_out(reset_threshold_out),
    .main_overvoltage_flag_out(main_overvoltage_flag_out),
    .overvoltage_restart_out(overvoltage_restart_out),
    .failure_outputs_out(failure_outputs_out), .watchdog_active_out(watchdog_active_out),
    .watchdog_window_out(watchdog_window_out),
    .watchdog_long_open_out(watchdog_long_open_out),
    .watchdog_escalate_out(watchdog_escalate_out),
    .watchdog_period_out(watchdog_period_out));
  msw_host u_host (.core_clk_in(core_clk_in), .rd_data_in(rd_data_out),
    .rd_valid_in(rd_valid_out), .cmd_valid_out(cmd_valid_in), .cmd_addr_out(cmd_addr_in),
    .cmd_write_out(cmd_write_in), .cmd_data_out(cmd_data_in), .last_rd_out(hrd),
    .rd_seen_out(hseen));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Value a register holds after a write
  function automatic logic [7:0] stored(input logic [6:0] r, input logic [7:0] v);
    if (r == MSW_ADDR_MODE) return v;
    if (r == MSW_ADDR_HW) return v & 8'hFB;
    if (r == MSW_ADDR_WD) return {^(v[6:0] & 7'h77), v[6:0] & 7'h77};
    return 8'h00;
  endfunction
  // Command plus check of the returned byte
  task automatic acc(input logic [6:0] r, input logic w, input logic [7:0] v,
      input logic [7:0] exp);
    u_host.send(r, w, v);
    chk(hseen, 1'b1);
    chk(hrd, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk_in);
    s = 1'b1;
    @(negedge core_clk_in);
    s = 1'b0;
  endtask
  // Control outputs against the shadow registers
  task automatic derived();
    @(negedge core_clk_in);
    chk(third_regulator_on_out, shadow[1][5]);
    chk(second_regulator_on_out, shadow[1][4:3] != 2'b00);
    chk(reset_threshold_out, shadow[1][1:0]);
    chk(third_regulator_alt_voltage_out, shadow[2][7]);
    chk(failure_outputs_out, shadow[2][5]);
    chk(load_sharing_out, shadow[2][3]);
    chk(watchdog_window_out, shadow[3][5]);
    chk(watchdog_period_out, shadow[3][2:0]);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(94));
    repeat (5) @(negedge core_clk_in);
    reset_in = 1'b0;
    shadow = '{8'h00, 8'h00, 8'h00, 8'h14};
    for (int i = 0; i < 4; i++) acc(7'(i), 1'b0, 8'h00, shadow[i]);
    acc(7'h40, 1'b1, 8'hFF, 8'h00);
    // Random writes, each followed by a check of the control outputs
    for (int i = 0; i < 40; i++) begin
      a = 7'(1 + $urandom % 3);
      d = 8'($urandom);
      if (a == MSW_ADDR_MODE) d[7:6] = 2'b00;
      if (d[2:0] == 3'h7) d[2:0] = 3'h6;
      acc(a, 1'b1, d, shadow[a]);
      shadow[a] = stored(a, d);
      derived();
    end
    supply_undervoltage_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk(third_regulator_on_out, shadow[1][5] & shadow[2][4]);
    supply_undervoltage_in = 1'b0;
    // Mode codes, stop to sleep refused
    acc(MSW_ADDR_MODE, 1'b1, 8'h00, shadow[1]);
    a = 7'h00;
    foreach (shadow[i]) begin
      d = (i == 0) ? 8'h40 : (i == 1) ? 8'h00 : 8'h80;
      acc(MSW_ADDR_MODE, 1'b1, d, {a[1:0], 6'h00});
      a = 7'(d[7:6]);
      @(negedge core_clk_in);
      chk(mode_out, a[1:0]);
    end
    acc(MSW_ADDR_MODE, 1'b1, 8'h40, 8'h80);
    @(negedge core_clk_in);
    chk(mode_out, MSW_CODE_STOP);
    // Soft reset with and without reset output
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h4A : 8'h8B;
      u_host.send(MSW_ADDR_HW, 1'b1, d);
      u_host.send(MSW_ADDR_WD, 1'b1, 8'h25);
      u_host.send(MSW_ADDR_MODE, 1'b1, 8'hC0);
      chk(soft_reset_out, 1'b1);
      chk(reset_output_low_out, !d[6]);
      acc(MSW_ADDR_HW, 1'b0, 8'h00, d & 8'h88);
      acc(MSW_ADDR_WD, 1'b0, 8'h00, 8'h14);
      acc(MSW_ADDR_MODE, 1'b0, 8'h00, 8'h00);
    end
    // Restart and overtemperature clear hardware-owned fields
    u_host.send(MSW_ADDR_MODE, 1'b1, 8'hB8);
    u_host.send(MSW_ADDR_HW, 1'b1, 8'h20);
    pulse(restart_in);
    acc(MSW_ADDR_MODE, 1'b0, 8'h00, 8'h20);
    acc(MSW_ADDR_HW, 1'b0, 8'h00, 8'h00);
    chk(failure_outputs_out, 1'b0);
    u_host.send(MSW_ADDR_MODE, 1'b1, 8'h18);
    pulse(overtemp_in);
    acc(MSW_ADDR_MODE, 1'b0, 8'h00, 8'h00);
    // Fault-driven failure output survives clearing the software bit
    pulse(fault_failure_in);
    u_host.send(MSW_ADDR_HW, 1'b1, 8'h00);
    repeat (2) @(negedge core_clk_in);
    chk(failure_outputs_out, 1'b1);
    pulse(failure_flag_clear_in);
    repeat (2) @(negedge core_clk_in);
    chk(failure_outputs_out, 1'b0);
    // Overvoltage flag always, reaction only when enabled
    for (int k = 0; k < 2; k++) begin
      u_host.send(MSW_ADDR_MODE, 1'b1, k ? 8'h04 : 8'h00);
      seen = 1'b0;
      pulse(overvoltage_in);
      repeat (3) begin
        seen = seen | overvoltage_restart_out;
        @(negedge core_clk_in);
      end
      chk(main_overvoltage_flag_out, 1'b1);
      chk(seen, k[0]);
    end
    // Stop mode: regulators, load sharing and watchdog controls
    for (int k = 0; k < 2; k++) begin
      u_host.send(MSW_ADDR_WD, 1'b1, k ? 8'h55 : 8'h05);
      u_host.send(MSW_ADDR_HW, 1'b1, k ? 8'h08 : 8'h0A);
      u_host.send(MSW_ADDR_MODE, 1'b1, k ? 8'hA8 : 8'hB0);
      @(negedge core_clk_in);
      chk(mode_out, MSW_CODE_STOP);
      chk(second_regulator_on_out, !k[0]);
      chk(load_sharing_out, !k[0]);
      chk(third_regulator_on_out, !k[0]);
      chk(watchdog_active_out, !k[0]);
      pulse(bus_wake_in);
      chk(watchdog_long_open_out, k[0]);
    end
    // Watchdog escalation after first or second failure
    for (int k = 0; k < 2; k++) begin
      u_host.send(MSW_ADDR_HW, 1'b1, 8'(k));
      pulse(restart_in);
      pulse(wd_fail_in);
      chk(watchdog_escalate_out, k[0]);
      pulse(wd_fail_in);
      chk(watchdog_escalate_out, 1'b1);
    end
    // Second regulator always on except in fail-safe
    u_host.send(MSW_ADDR_MODE, 1'b1, 8'h18);
    fail_safe_in = 1'b1;
    @(negedge core_clk_in);
    chk(second_regulator_on_out, 1'b0);
    fail_safe_in = 1'b0;
    @(negedge core_clk_in);
    chk(second_regulator_on_out, 1'b1);
    wrap_up();
  end
endmodule
